// ==== pkg/hse_defines.vh ====
// Purpose: shared constants of the store and exclusive-or execution block
// Assumes: 32-bit AHB-Lite register bus, byte addresses
// Notes: definitions only
`ifndef HSE_DEFINES_VH
`define HSE_DEFINES_VH

// ==========================================================
// register map (byte addresses)
`define HSE_INSTR_OFS 12'h000
`define HSE_STATUS_OFS 12'h004
`define HSE_FLAGS_OFS 12'h008
`define HSE_REGWIN_OFS 12'h800

// ==========================================================
// status and flag fields
`define HSE_ST_BUSY 0
`define HSE_ST_Z 1
`define HSE_ST_C 2
`define HSE_ST_UNSUP 3
`define HSE_ST_SKIP 4
`define HSE_FL_Z 0
`define HSE_FL_C 1

// ==========================================================
// instruction word fields
`define HSE_OPC_HI 31
`define HSE_OPC_LO 26
`define HSE_EF_Z 25
`define HSE_EF_C 24
`define HSE_EF_R 23
`define HSE_EF_I 22
`define HSE_CON_HI 21
`define HSE_CON_LO 18
`define HSE_DST_HI 17
`define HSE_DST_LO 9
`define HSE_SRC_HI 8
`define HSE_SRC_LO 0

// ==========================================================
// opcodes
`define HSE_OP_STB 6'h00
`define HSE_OP_STH 6'h01
`define HSE_OP_STF 6'h02
`define HSE_OP_XOR 6'h1B
`define HSE_OP_UCOMP 6'h21

// ==========================================================
// size codes on the memory port
`define HSE_SZ_BYTE 2'h0
`define HSE_SZ_HALF 2'h1
`define HSE_SZ_FULL 2'h2

// ==========================================================
// timing, in clock cycles
`define HSE_XOR_CYC 5'h04
`define HSE_CMP_CYC 5'h04
`define HSE_STORE_PRE 5'h05

`endif

// ==== core/hse_core.v ====
// Purpose: execution of the three store instructions, exclusive-or and
//          unsigned compare, with the zero and carry flag effects
// Assumes: arbiter raises mem_slot for one cycle in this core's access slot
// Notes: registers reached over AHB-Lite, zero wait states
//
// Operation
// - store byte writes low 8 bits
// - store halfword writes low 16 bits
// - store fullword writes all 32 bits
// - store address from source field or literal
// - stores take 7 to 22 cycles
// - stores never write back; result bit means load, which this core flags unsupported
// - byte store Z set unless word aligned
// - halfword store Z from address bit 1
// - fullword store always clears Z
// - Z changes only with zero effect or a flags register write
// - compare sets Z when operands equal
// - exclusive-or result stored only with result effect
// - exclusive-or literal source is zero-extended
// - exclusive-or Z set when result zero
// - exclusive-or C is odd parity
// - exclusive-or opcode decode, four cycles
// - result effect writes destination register
// - C changes only with carry effect or a flags register write
`timescale 1ns/1ps
`include "hse_defines.vh"

module hse_core #(
    parameter REG_DEPTH = 512,
    parameter ADDR_W = 16
) (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // ahb-lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // shared memory port
    input wire mem_slot,
    output reg mem_req,
    output reg [ADDR_W-1:0] mem_addr,
    output reg [31:0] mem_wdata,
    output reg [1:0] mem_size,
    // flags
    output reg z_flag,
    output reg c_flag,
    output reg busy
);

    localparam S_IDLE = 4'b0001;
    localparam S_PRE = 4'b0010;
    localparam S_SLOT = 4'b0100;
    localparam S_POST = 4'b1000;

    // ==========================================================
    // functions
    function parity32;
        input [31:0] v;
        begin
            parity32 = ^v;
        end
    endfunction

    // condition field: one enable bit per {C,Z} combination
    function cond_ok;
        input [3:0] cond;
        input zf;
        input cf;
        begin
            cond_ok = cond[{cf, zf}];
        end
    endfunction

    // ==========================================================
    // state
    reg [31:0] regs [0:REG_DEPTH-1];
    reg [3:0] state_q;
    reg [4:0] cnt_q;
    reg [31:0] instr_q;
    reg is_store_q;
    reg wz_q;
    reg wc_q;
    reg wres_q;
    reg [8:0] dst_q;
    reg [31:0] res_q;
    reg zres_q;
    reg cres_q;
    reg unsup_q;
    reg skip_q;
    reg dph_wr_q;
    reg [11:0] dph_addr_q;

    // ==========================================================
    // bus address phase decode
    wire acc = hsel & hready & htrans[1];
    wire [11:0] ofs = haddr[11:0];
    wire in_win = ofs >= `HSE_REGWIN_OFS;
    wire [8:0] widx = ofs[10:2];

    reg [31:0] rd_d;
    always @* begin
        rd_d = 32'h0000_0000;
        if (in_win) begin
            rd_d = regs[widx];
        end else if (ofs == `HSE_INSTR_OFS) begin
            rd_d = instr_q;
        end else if (ofs == `HSE_STATUS_OFS) begin
            rd_d[`HSE_ST_BUSY] = busy;
            rd_d[`HSE_ST_Z] = z_flag;
            rd_d[`HSE_ST_C] = c_flag;
            rd_d[`HSE_ST_UNSUP] = unsup_q;
            rd_d[`HSE_ST_SKIP] = skip_q;
        end else if (ofs == `HSE_FLAGS_OFS) begin
            rd_d[`HSE_FL_Z] = z_flag;
            rd_d[`HSE_FL_C] = c_flag;
        end
    end

    // ==========================================================
    // decode of an instruction written in the data phase
    wire issue = dph_wr_q & (dph_addr_q == `HSE_INSTR_OFS) & ~busy;
    wire [5:0] opc = hwdata[`HSE_OPC_HI:`HSE_OPC_LO];
    wire ef_z = hwdata[`HSE_EF_Z];
    wire ef_c = hwdata[`HSE_EF_C];
    wire ef_r = hwdata[`HSE_EF_R];
    wire ef_i = hwdata[`HSE_EF_I];
    wire [8:0] dfield = hwdata[`HSE_DST_HI:`HSE_DST_LO];
    wire [8:0] sfield = hwdata[`HSE_SRC_HI:`HSE_SRC_LO];
    wire [31:0] dval = regs[dfield];
    wire [31:0] sval = ef_i ? {23'h000000, sfield} : regs[sfield];
    wire op_st = (opc == `HSE_OP_STB) | (opc == `HSE_OP_STH) | (opc == `HSE_OP_STF);
    wire dec_store = op_st & ~ef_r;
    wire dec_xor = opc == `HSE_OP_XOR;
    wire dec_ucomp = opc == `HSE_OP_UCOMP;
    wire known = dec_store | dec_xor | dec_ucomp;
    wire run = cond_ok(hwdata[`HSE_CON_HI:`HSE_CON_LO], z_flag, c_flag);
    wire [31:0] xres = dval ^ sval;
    wire [ADDR_W-1:0] saddr = sval[ADDR_W-1:0];

    // store zero result from address alignment
    reg st_z;
    always @* begin
        st_z = 1'b0;
        if (opc == `HSE_OP_STB) begin
            st_z = saddr[1:0] != 2'h0;
        end else if (opc == `HSE_OP_STH) begin
            st_z = saddr[1];
        end else begin
            st_z = 1'b0;
        end
    end

    // ==========================================================
    // bus slave and register file
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            dph_wr_q <= 1'b0;
            dph_addr_q <= 12'h000;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            dph_wr_q <= acc & hwrite;
            if (acc) begin
                dph_addr_q <= ofs;
            end
            if (acc & ~hwrite) begin
                hrdata <= rd_d;
            end
        end
    end

    // write-back wins over a bus write to the same word in the same cycle
    always @(posedge hclk) begin
        if (dph_wr_q & (dph_addr_q >= `HSE_REGWIN_OFS)) begin
            regs[dph_addr_q[10:2]] <= hwdata;
        end
        if (state_q == S_PRE && cnt_q == 5'h00 && !is_store_q && wres_q) begin
            regs[dst_q] <= res_q;
        end
    end

    // ==========================================================
    // execution sequencer
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= S_IDLE;
            cnt_q <= 5'h00;
            instr_q <= 32'h0000_0000;
            is_store_q <= 1'b0;
            wz_q <= 1'b0;
            wc_q <= 1'b0;
            wres_q <= 1'b0;
            dst_q <= 9'h000;
            res_q <= 32'h0000_0000;
            zres_q <= 1'b0;
            cres_q <= 1'b0;
            unsup_q <= 1'b0;
            skip_q <= 1'b0;
            busy <= 1'b0;
            z_flag <= 1'b0;
            c_flag <= 1'b0;
            mem_req <= 1'b0;
            mem_addr <= {ADDR_W{1'b0}};
            mem_wdata <= 32'h0000_0000;
            mem_size <= `HSE_SZ_BYTE;
        end else begin
            if (dph_wr_q & (dph_addr_q == `HSE_FLAGS_OFS) & ~busy) begin
                z_flag <= hwdata[`HSE_FL_Z];
                c_flag <= hwdata[`HSE_FL_C];
            end
            case (state_q)
                S_IDLE: begin
                    if (issue) begin
                        instr_q <= hwdata;
                        unsup_q <= ~known;
                        skip_q <= known & ~run;
                        if (known & run) begin
                            busy <= 1'b1;
                            state_q <= S_PRE;
                            is_store_q <= dec_store;
                            wz_q <= ef_z;
                            wc_q <= ef_c;
                            wres_q <= dec_xor ? ef_r : (dec_ucomp & ef_r);
                            dst_q <= dfield;
                            if (dec_store) begin
                                cnt_q <= `HSE_STORE_PRE - 5'h01;
                                zres_q <= st_z;
                                cres_q <= 1'b0;
                                mem_addr <= saddr;
                                if (opc == `HSE_OP_STB) begin
                                    mem_wdata <= {24'h000000, dval[7:0]};
                                    mem_size <= `HSE_SZ_BYTE;
                                end else if (opc == `HSE_OP_STH) begin
                                    mem_wdata <= {16'h0000, dval[15:0]};
                                    mem_size <= `HSE_SZ_HALF;
                                end else begin
                                    mem_wdata <= dval;
                                    mem_size <= `HSE_SZ_FULL;
                                end
                            end else if (dec_xor) begin
                                cnt_q <= `HSE_XOR_CYC - 5'h01;
                                res_q <= xres;
                                zres_q <= xres == 32'h0000_0000;
                                cres_q <= parity32(xres);
                            end else begin
                                cnt_q <= `HSE_CMP_CYC - 5'h01;
                                res_q <= dval - sval;
                                zres_q <= dval == sval;
                                cres_q <= dval < sval;
                            end
                        end
                    end
                end
                S_PRE: begin
                    if (cnt_q != 5'h00) begin
                        cnt_q <= cnt_q - 5'h01;
                    end else if (is_store_q) begin
                        mem_req <= 1'b1;
                        state_q <= S_SLOT;
                    end else begin
                        if (wz_q) begin
                            z_flag <= zres_q;
                        end
                        if (wc_q) begin
                            c_flag <= cres_q;
                        end
                        busy <= 1'b0;
                        state_q <= S_IDLE;
                    end
                end
                S_SLOT: begin
                    // arbiter takes the write in the cycle of its slot
                    if (mem_slot) begin
                        mem_req <= 1'b0;
                        state_q <= S_POST;
                    end
                end
                S_POST: begin
                    if (wz_q) begin
                        z_flag <= zres_q;
                    end
                    if (wc_q) begin
                        c_flag <= cres_q;
                    end
                    busy <= 1'b0;
                    state_q <= S_IDLE;
                end
                default: begin
                    state_q <= S_IDLE;
                    busy <= 1'b0;
                    mem_req <= 1'b0;
                end
            endcase
        end
    end

endmodule // hse_core

// ==== tb/hse_core_monitor.sv ====
// Purpose: port checker for the store and exclusive-or block
// Assumes: one slot pulse per arbiter period, zero wait state bus
// Notes: bind stands after the module
`timescale 1ns/1ps
module hse_core_monitor #(
    parameter REG_DEPTH = 512,
    parameter ADDR_W = 16
) (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // bus
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hreadyout,
    // memory port
    input wire mem_slot,
    input wire mem_req,
    input wire [ADDR_W-1:0] mem_addr,
    input wire [31:0] mem_wdata,
    input wire [1:0] mem_size,
    // flags
    input wire z_flag,
    input wire c_flag,
    input wire busy
);
    // ==========================================
    // helper logic
    reg [4:0] cnt_q;
    reg st_q;
    reg fw_q;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 5'h00;
            st_q <= 1'b0;
            fw_q <= 1'b0;
        end else begin
            cnt_q <= busy ? cnt_q + 5'h01 : 5'h00;
            st_q <= busy && (st_q || mem_req);
            // a flags preload is a legal flag change too
            fw_q <= hsel && hreadyout && htrans[1] && hwrite && haddr[11:0] == 12'h008;
        end
    end
    // ==========================================
    // assertions
    req_in_busy_a: assert property (mem_req |-> busy)
        else $error("request outside busy");
    req_hold_a: assert property (mem_req && !mem_slot |=> mem_req)
        else $error("request dropped before slot");
    req_done_a: assert property (mem_req && mem_slot |=> !mem_req ##1 !busy)
        else $error("store did not retire after slot");
    req_delay_a: assert property ($rose(mem_req) |-> $past(busy, 4))
        else $error("request raised too early");
    addr_stable_a: assert property (busy && $past(busy) |->
        $stable(mem_addr) && $stable(mem_wdata))
        else $error("store address or data moved");
    byte_data_a: assert property (mem_req && mem_size == 2'h0 |->
        mem_wdata[31:8] == 24'h000000)
        else $error("byte store upper bits set");
    half_data_a: assert property (mem_req && mem_size == 2'h1 |->
        mem_wdata[31:16] == 16'h0000)
        else $error("half store upper bits set");
    size_ok_a: assert property (mem_req |-> mem_size != 2'h3)
        else $error("bad store size");
    busy_len_a: assert property (!busy && cnt_q != 5'h00 |->
        (st_q ? (cnt_q >= 5'h07 && cnt_q <= 5'h16) : cnt_q == 5'h04))
        else $error("instruction length wrong");
    z_hold_a: assert property (z_flag != $past(z_flag) |-> $past(busy) || $past(fw_q))
        else $error("zero flag changed without cause");
    c_hold_a: assert property (c_flag != $past(c_flag) |-> $past(busy) || $past(fw_q))
        else $error("carry flag changed without cause");
endmodule // hse_core_monitor

bind hse_core hse_core_monitor #(.REG_DEPTH(REG_DEPTH), .ADDR_W(ADDR_W)) u_mon (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hreadyout(hreadyout), .mem_slot(mem_slot), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_size(mem_size), .z_flag(z_flag), .c_flag(c_flag), .busy(busy));

// ==== tb/hse_arbiter_model.sv ====
// Purpose: shared memory arbiter with a rotating one-cycle slot
// Assumes: slot every PERIOD cycles whether requested or not
// Notes: last accepted store is held for the bench
`timescale 1ns/1ps
module hse_arbiter_model #(
    parameter PERIOD = 16
) (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // memory port
    input wire mem_req,
    input wire [15:0] mem_addr,
    input wire [31:0] mem_wdata,
    input wire [1:0] mem_size,
    output reg mem_slot,
    // captured store
    output reg [31:0] cap_n,
    output reg [15:0] cap_addr,
    output reg [31:0] cap_data,
    output reg [1:0] cap_size
);
    reg [7:0] ph_q;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_q <= 8'h00;
            mem_slot <= 1'b0;
            cap_n <= 32'h0;
        end else begin
            ph_q <= (ph_q == PERIOD - 1) ? 8'h00 : ph_q + 8'h01;
            mem_slot <= ph_q == 8'h00;
            if (mem_slot && mem_req) begin
                cap_n <= cap_n + 32'h1;
                cap_addr <= mem_addr;
                cap_data <= mem_wdata;
                cap_size <= mem_size;
            end
        end
    end
endmodule // hse_arbiter_model

// ==== tb/tb.sv ====
// Purpose: self-checking bench for the store and exclusive-or block
// Assumes: zero wait state slave, arbiter slot every 16 cycles
// Notes: expectations come from an integer model in the bench
`timescale 1ns/1ps
module tb;
    reg hclk = 1'b0;
    reg hresetn = 1'b0;
    reg hsel = 1'b0;
    reg [31:0] haddr = 32'h0;
    reg [1:0] htrans = 2'h0;
    reg hwrite = 1'b0;
    reg [31:0] hwdata = 32'h0;
    reg [2:0] hsize = 3'h0;
    wire [31:0] hrdata, mem_wdata, cap_n, cap_data;
    wire [15:0] mem_addr, cap_addr;
    wire [1:0] mem_size, cap_size;
    wire hreadyout, hresp, mem_slot, mem_req, z_flag, c_flag, busy;
    integer seed = 32'h1f51955d;
    integer error_cnt = 0;
    integer checks_done = 0;
    integer cyc = 0;
    integer i, k;
    reg [31:0] rd, dv, sv, so, res, ea, mk;
    reg [3:0] ef;
    reg [1:0] zc;
    reg [5:0] op;
    reg ez, ec;
    hse_core DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .mem_slot(mem_slot), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_size(mem_size), .z_flag(z_flag),
        .c_flag(c_flag), .busy(busy));
    hse_arbiter_model u_arb (.hclk(hclk), .hresetn(hresetn), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_size(mem_size), .mem_slot(mem_slot),
        .cap_n(cap_n), .cap_addr(cap_addr), .cap_data(cap_data), .cap_size(cap_size));
    always #5 hclk = ~hclk;
    // ==========================================
    // tasks
    task finish_test;
        begin
            $display("errors %0d checks %0d", error_cnt, checks_done);
            if (error_cnt == 0 && checks_done > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    task chk(input [31:0] g, input [31:0] e);
        begin
            checks_done = checks_done + 1;
            if (g !== e) begin
                error_cnt = error_cnt + 1;
                $display("[ERR] %0t got %h want %h", $time, g, e);
            end
        end
    endtask
    // one single word transfer, read data kept in rd
    task xfer(input [31:0] a, input w, input [31:0] wd);
        begin
            hsel <= 1'b1;
            haddr <= a;
            htrans <= 2'h2;
            hwrite <= w;
            hsize <= 3'h2;
            @(posedge hclk);
            while (hreadyout !== 1'b1) @(posedge hclk);
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= wd;
            @(posedge hclk);
            while (hreadyout !== 1'b1) @(posedge hclk);
            rd = hrdata;
            chk({31'h0, hresp}, 32'h0);
        end
    endtask
    // issue, then poll busy; rd ends holding the last status
    task exec(input [31:0] ins);
        begin
            xfer(32'h0, 1'b1, ins);
            rd = 32'h1;
            while (rd[0] !== 1'b0) xfer(32'h4, 1'b0, 32'h0);
        end
    endtask
    always @(posedge hclk) begin
        cyc = cyc + 1;
        if (cyc == 30000) begin
            error_cnt = error_cnt + 1;
            finish_test;
        end
    end
    // ==========================================
    // main sequence
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(32'hC, 1'b1, 32'hFFFFFFFF);
        xfer(32'hC, 1'b0, 32'h0);
        chk(rd, 32'h0);
        xfer(32'h8, 1'b0, 32'h0);
        chk(rd, 32'h0);
        // condition not met: skipped, no flag or register change
        xfer(32'h804, 1'b1, 32'h5);
        exec({6'h1B, 4'hE, 4'hE, 9'h001, 9'h001});
        chk({27'h0, rd[4:0]}, 32'h10);
        xfer(32'h804, 1'b0, 32'h0);
        chk(rd, 32'h5);
        for (i = 0; i < 38; i = i + 1) begin
            dv = $random(seed);
            sv = (i == 0) ? dv : $random(seed);
            zc = $random(seed);
            ef = (i == 0) ? 4'hE : $random(seed);
            op = (i < 24) ? 6'h1B : (i < 26) ? 6'h21 : (i % 3);
            if (i >= 35)
                ef[1] = 1'b1;
            else if (i >= 24)
                ef[1] = (i == 25);
            if (i == 24) begin
                sv = dv;
                ef = 4'hC;
            end
            xfer(32'h804, 1'b1, dv);
            xfer(32'h808, 1'b1, sv);
            xfer(32'h8, 1'b1, {30'h0, zc});
            so = ef[0] ? {23'h0, sv[8:0]} : sv;
            k = cap_n;
            exec({op, ef, 4'hF, 9'h001, ef[0] ? sv[8:0] : 9'h002});
            res = (op == 6'h21) ? dv - so : dv ^ so;
            ez = ef[3] ? (res == 32'h0) : zc[0];
            ec = ef[2] ? ^res : zc[1];
            if (op == 6'h21)
                ez = ef[3] ? (dv == so) : zc[0];
            if (op == 6'h21)
                ec = ef[2] ? (dv < so) : zc[1];
            if (op < 6'h03) begin
                ea = {16'h0, so[15:0]};
                ez = ef[3] ? (op == 6'h0 ? ea[1:0] != 2'h0 : op == 6'h1 ? ea[1] : 1'b0) : zc[0];
                ec = ef[2] ? 1'b0 : zc[1];
            end
            if (ef[1] && op < 6'h03) begin
                chk({31'h0, rd[3]}, 32'h1);
                chk(cap_n, k);
                ez = zc[0];
                ec = zc[1];
            end else if (op < 6'h03) begin
                chk(cap_n, k + 1);
                chk({16'h0, cap_addr}, ea);
                mk = (op == 6'h0) ? 32'hFF : (op == 6'h1) ? 32'hFFFF : 32'hFFFFFFFF;
                chk(cap_data, dv & mk);
                chk({30'h0, cap_size}, {26'h0, op});
            end
            xfer(32'h8, 1'b0, 32'h0);
            chk(rd, {30'h0, ec, ez});
            chk({30'h0, c_flag, z_flag}, {30'h0, ec, ez});
            xfer(32'h804, 1'b0, 32'h0);
            chk(rd, (op > 6'h02 && ef[1]) ? res : dv);
        end
        finish_test;
    end
endmodule // tb
